/* logic/rata_pkg.sv */
package rata_pkg;

  // Clock and timebase
  localparam int unsigned RATA_CLK_HZ         = 200_000_000;
  localparam int unsigned RATA_RTC_HZ         = 32768;
  localparam int unsigned RATA_RTC_DIV        = RATA_CLK_HZ / RATA_RTC_HZ;
  localparam logic [14:0] RATA_HALF_SEC_TICKS = 15'h4000;
  localparam logic [14:0] RATA_GUARD_TICKS    = 15'h0020;

  // Register offsets
  localparam logic [7:0] RATA_OFS_ALARM    = 8'h00;
  localparam logic [7:0] RATA_OFS_TIME     = 8'h04;
  localparam logic [7:0] RATA_OFS_CTRL     = 8'h08;
  localparam logic [7:0] RATA_OFS_ADATE    = 8'h0c;
  localparam logic [7:0] RATA_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] RATA_OFS_IRQ_MASK = 8'h14;

  // Field positions
  localparam int unsigned RATA_ALM_ARM    = 15;
  localparam int unsigned RATA_ALM_WRAP   = 14;
  localparam int unsigned RATA_ALM_PIV    = 13;
  localparam int unsigned RATA_ALM_UNSAFE = 12;
  localparam int unsigned RATA_ALM_IVL    = 8;
  localparam int unsigned RATA_ALM_RPT    = 0;
  localparam int unsigned RATA_CTRL_ON    = 15;
  localparam int unsigned RATA_CTRL_UNLK  = 3;
  localparam int unsigned RATA_TM_H10     = 28;
  localparam int unsigned RATA_TM_H1      = 24;
  localparam int unsigned RATA_TM_M10     = 20;
  localparam int unsigned RATA_TM_M1      = 16;
  localparam int unsigned RATA_TM_S10     = 12;
  localparam int unsigned RATA_TM_S1      = 8;
  localparam int unsigned RATA_AD_MONTH   = 8;
  localparam int unsigned RATA_AD_DAY     = 0;
  localparam int unsigned RATA_IRQ_ALARM  = 0;
  localparam int unsigned RATA_IRQ_EXPIRE = 1;

  // Alarm interval codes
  localparam logic [3:0] RATA_IVL_HALF    = 4'h0;
  localparam logic [3:0] RATA_IVL_SEC     = 4'h1;
  localparam logic [3:0] RATA_IVL_TEN_SEC = 4'h2;
  localparam logic [3:0] RATA_IVL_MIN     = 4'h3;
  localparam logic [3:0] RATA_IVL_TEN_MIN = 4'h4;
  localparam logic [3:0] RATA_IVL_HOUR    = 4'h5;
  localparam logic [3:0] RATA_IVL_DAY     = 4'h6;
  localparam logic [3:0] RATA_IVL_WEEK    = 4'h7;
  localparam logic [3:0] RATA_IVL_MONTH   = 4'h8;
  localparam logic [3:0] RATA_IVL_YEAR    = 4'h9;

  // Reset values and limits
  localparam logic [4:0] RATA_DAY_RST   = 5'h01;
  localparam logic [3:0] RATA_MONTH_RST = 4'h1;
  localparam logic [3:0] RATA_MONTH_MAX = 4'hc;
  localparam logic [6:0] RATA_YEAR_MAX  = 7'h63;
  localparam logic [2:0] RATA_DOW_MAX   = 3'h6;
  localparam logic [7:0] RATA_RPT_MAX   = 8'hff;

  // Returns {wrapped, next digit}
  function automatic logic [4:0] rata_bcd_inc(input logic [3:0] d, input logic [3:0] max);
    if (d >= max) begin
      rata_bcd_inc = 5'h10;
    end else begin
      rata_bcd_inc = {1'b0, d + 4'h1};
    end
  endfunction

  function automatic logic [4:0] rata_days_in_month(input logic [3:0] m, input logic leap);
    case (m)
      4'h2:                      rata_days_in_month = leap ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb:    rata_days_in_month = 5'h1e;
      default:                   rata_days_in_month = 5'h1f;
    endcase
  endfunction

endpackage

/* logic/rata_tick_if.sv */
`timescale 1ns/10ps
interface rata_tick_if;
  logic       half_sec;
  logic       read_unsafe;
  logic       sec_roll;
  logic       ten_sec_roll;
  logic       min_roll;
  logic       ten_min_roll;
  logic       hour_roll;
  logic       day_roll;
  logic       week_roll;
  logic       month_roll;
  logic       year_hit;
  logic [3:0] alarm_month;
  logic [4:0] alarm_day;

  modport timebase (output half_sec, output read_unsafe);
  modport tod (input half_sec, input alarm_month, input alarm_day,
               output sec_roll, output ten_sec_roll, output min_roll, output ten_min_roll,
               output hour_roll, output day_roll, output week_roll, output month_roll,
               output year_hit);
  modport core (input half_sec, input read_unsafe, input sec_roll, input ten_sec_roll,
                input min_roll, input ten_min_roll, input hour_roll, input day_roll,
                input week_roll, input month_roll, input year_hit,
                output alarm_month, output alarm_day);
endinterface

/* logic/rata_timebase.sv */
`timescale 1ns/10ps
module rata_timebase #(
  parameter int unsigned RTC_DIV = rata_pkg::RATA_RTC_DIV
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           enable,
  rata_tick_if.timebase       tick
);
  import rata_pkg::*;

  localparam logic [15:0] DIV_LAST = 16'(RTC_DIV - 1);

  typedef struct packed {
    logic [15:0] div;
    logic [14:0] pre;
    logic        half;
    logic        unsafe;
  } rata_tb_state_t;

  rata_tb_state_t st;
  rata_tb_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.half = 1'b0;
    if (enable) begin
      if (st.div == DIV_LAST) begin
        next_st.div = '0;
        if (st.pre == RATA_HALF_SEC_TICKS - 15'h0001) begin
          next_st.pre  = '0;
          next_st.half = 1'b1;
        end else begin
          next_st.pre = st.pre + 15'h0001;
        end
      end else begin
        next_st.div = st.div + 16'h0001;
      end
    end
    // Guard both sides of the rollover; a read that straddles it sees torn bits
    next_st.unsafe = (next_st.pre >= RATA_HALF_SEC_TICKS - RATA_GUARD_TICKS) ||
                     (next_st.pre < RATA_GUARD_TICKS);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick.half_sec    = st.half;
  assign tick.read_unsafe = st.unsafe;
endmodule // rata_timebase

/* logic/rata_tod.sv */
`timescale 1ns/10ps
module rata_tod (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        soft_reset,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] time_value,
  rata_tick_if.tod         tick
);
  import rata_pkg::*;

  typedef struct packed {
    logic       phase;
    logic [3:0] h10, h1, m10, m1, s10, s1;
    logic [4:0] day;
    logic [3:0] month;
    logic [6:0] year;
    logic [2:0] dow;
    logic [8:0] rolls;
    logic       year_hit;
  } rata_tod_state_t;

  localparam rata_tod_state_t TOD_RST = '{day: RATA_DAY_RST, month: RATA_MONTH_RST,
                                         default: '0};

  rata_tod_state_t st;
  rata_tod_state_t next_st;
  logic            c;

  always_comb begin
    c                = 1'b0;
    next_st          = st;
    next_st.rolls    = '0;
    next_st.year_hit = 1'b0;
    if (soft_reset) begin
      next_st = TOD_RST;
    end else if (wr_en) begin
      next_st.h10 = wr_data[RATA_TM_H10 +: 4];
      next_st.h1  = wr_data[RATA_TM_H1 +: 4];
      next_st.m10 = wr_data[RATA_TM_M10 +: 4];
      next_st.m1  = wr_data[RATA_TM_M1 +: 4];
      next_st.s10 = wr_data[RATA_TM_S10 +: 4];
      next_st.s1  = wr_data[RATA_TM_S1 +: 4];
    end else if (tick.half_sec) begin
      next_st.phase = ~st.phase;
      if (st.phase) begin
        next_st.rolls[0]  = 1'b1;
        {c, next_st.s1}   = rata_bcd_inc(st.s1, 4'h9);
        next_st.rolls[1]  = c;
        if (c) {c, next_st.s10} = rata_bcd_inc(st.s10, 4'h5);
        next_st.rolls[2]  = c;
        if (c) {c, next_st.m1} = rata_bcd_inc(st.m1, 4'h9);
        next_st.rolls[3]  = c;
        if (c) {c, next_st.m10} = rata_bcd_inc(st.m10, 4'h5);
        next_st.rolls[4]  = c;
        if (c) {c, next_st.h1} = rata_bcd_inc(st.h1, (st.h10 == 4'h2) ? 4'h3 : 4'h9);
        if (c) {c, next_st.h10} = rata_bcd_inc(st.h10, 4'h2);
        if (c) begin
          next_st.rolls[5] = 1'b1;
          // Plain leap rule, so Feb 29 exists only every fourth year
          if (st.day >= rata_days_in_month(st.month, st.year[1:0] == 2'h0)) begin
            next_st.day      = RATA_DAY_RST;
            next_st.rolls[7] = 1'b1;
            if (st.month == RATA_MONTH_MAX) begin
              next_st.month = RATA_MONTH_RST;
              next_st.year  = (st.year == RATA_YEAR_MAX) ? 7'h00 : st.year + 7'h01;
            end else begin
              next_st.month = st.month + 4'h1;
            end
          end else begin
            next_st.day = st.day + 5'h01;
          end
          next_st.dow      = (st.dow == RATA_DOW_MAX) ? 3'h0 : st.dow + 3'h1;
          next_st.rolls[6] = (st.dow == RATA_DOW_MAX);
          next_st.year_hit = (next_st.day == tick.alarm_day) &&
                             (next_st.month == tick.alarm_month);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= TOD_RST;
    end else begin
      st <= next_st;
    end
  end

  assign time_value        = {st.h10, st.h1, st.m10, st.m1, st.s10, st.s1, 8'h00};
  assign tick.sec_roll     = st.rolls[0];
  assign tick.ten_sec_roll = st.rolls[1];
  assign tick.min_roll     = st.rolls[2];
  assign tick.ten_min_roll = st.rolls[3];
  assign tick.hour_roll    = st.rolls[4];
  assign tick.day_roll     = st.rolls[5];
  assign tick.week_roll    = st.rolls[6];
  assign tick.month_roll   = st.rolls[7];
  assign tick.year_hit     = st.year_hit;
endmodule // rata_tod

/* logic/rata_top.sv */
//
// Contract
// - Alarm control bit 15 arms the alarm at one, disarms at zero.
// - With repeat wrap on, repeat counter wraps from 0x00 to 0xFF.
// - With repeat wrap off, repeat counter holds at 0x00.
// - Disarmed: pulse initial bit writable and sets the alarm pulse level.
// - Armed: pulse initial bit ignores writes, reads back live pulse level.
// - Read-unsafe flag set near half-second rollover, clear beyond 32 RTC ticks.
// - Four-bit interval code picks half-second up to yearly; 1010-1111 reserved.
// - A yearly alarm on February 29 fires only in leap years.
// - Alarm event with count zero and wrap off clears the arm bit.
// - Alarm control is cleared only by power-on reset.
// - Hours BCD: tens in bits 31-28, units in bits 27-24.
// - Minutes BCD: tens in bits 23-20, units in bits 19-16.
// - Seconds BCD: tens 15-12, units 11-8, bits 7-0 read zero.
// - Time register writes are ignored unless time-write unlock is one.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module rata_top #(
  parameter int unsigned RTC_DIV = rata_pkg::RATA_RTC_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        soft_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             alarm_pulse,
  output logic             irq
);
  import rata_pkg::*;

  typedef struct packed {
    logic        arm;
    logic        wrap;
    logic [3:0]  ivl;
    logic [7:0]  rpt;
    logic        pulse;
    logic        ctrl_on;
    logic        ctrl_unlock;
    logic [3:0]  ad_month;
    logic [4:0]  ad_day;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [31:0] rdata;
    logic        err;
  } rata_core_state_t;

  localparam rata_core_state_t CORE_RST = '{ad_month: RATA_MONTH_RST, ad_day: RATA_DAY_RST,
                                           default: '0};

  rata_core_state_t st;
  rata_core_state_t next_st;
  rata_tick_if      tick ();
  logic             ivl_hit;
  logic             alarm_event;
  logic             setup;
  logic             wr;
  logic             mapped;
  logic [31:0]      time_value;
  logic [31:0]      rd_mux;
  logic [1:0]       irq_set;

  rata_timebase #(
    .RTC_DIV (RTC_DIV)
  ) u_timebase (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (st.ctrl_on),
    .tick    (tick.timebase)
  );

  rata_tod u_tod (
    .pclk       (pclk),
    .presetn    (presetn),
    .soft_reset (soft_reset),
    .wr_en      (wr && paddr == RATA_OFS_TIME && st.ctrl_unlock),
    .wr_data    (pwdata),
    .time_value (time_value),
    .tick       (tick.tod)
  );

  assign tick.alarm_month = st.ad_month;
  assign tick.alarm_day   = st.ad_day;

  // Reserved codes never fire
  always_comb begin
    case (st.ivl)
      RATA_IVL_HALF:    ivl_hit = tick.half_sec;
      RATA_IVL_SEC:     ivl_hit = tick.sec_roll;
      RATA_IVL_TEN_SEC: ivl_hit = tick.ten_sec_roll;
      RATA_IVL_MIN:     ivl_hit = tick.min_roll;
      RATA_IVL_TEN_MIN: ivl_hit = tick.ten_min_roll;
      RATA_IVL_HOUR:    ivl_hit = tick.hour_roll;
      RATA_IVL_DAY:     ivl_hit = tick.day_roll;
      RATA_IVL_WEEK:    ivl_hit = tick.week_roll;
      RATA_IVL_MONTH:   ivl_hit = tick.month_roll;
      RATA_IVL_YEAR:    ivl_hit = tick.year_hit;
      default:          ivl_hit = 1'b0;
    endcase
  end

  assign alarm_event = st.arm && ivl_hit;
  assign setup       = psel && !penable;
  assign wr          = psel && penable && pwrite;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      RATA_OFS_ALARM: begin
        rd_mux = 32'h0000_0000;
        rd_mux[RATA_ALM_ARM]    = st.arm;
        rd_mux[RATA_ALM_WRAP]   = st.wrap;
        rd_mux[RATA_ALM_PIV]    = st.pulse;
        rd_mux[RATA_ALM_UNSAFE] = tick.read_unsafe;
        rd_mux[RATA_ALM_IVL +: 4] = st.ivl;
        rd_mux[RATA_ALM_RPT +: 8] = st.rpt;
      end
      RATA_OFS_TIME:     rd_mux = time_value;
      RATA_OFS_CTRL: begin
        rd_mux = 32'h0000_0000;
        rd_mux[RATA_CTRL_ON]   = st.ctrl_on;
        rd_mux[RATA_CTRL_UNLK] = st.ctrl_unlock;
      end
      RATA_OFS_ADATE: begin
        rd_mux = 32'h0000_0000;
        rd_mux[RATA_AD_MONTH +: 4] = st.ad_month;
        rd_mux[RATA_AD_DAY +: 5]   = st.ad_day;
      end
      RATA_OFS_IRQ_STAT: rd_mux = {30'h0, st.irq_stat};
      RATA_OFS_IRQ_MASK: rd_mux = {30'h0, st.irq_mask};
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    irq_set = 2'b00;
    // Read data and error are latched at setup so the access phase needs no wait
    if (setup) begin
      next_st.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      next_st.err   = !mapped;
    end
    if (alarm_event) begin
      next_st.pulse = ~st.pulse;
      irq_set[RATA_IRQ_ALARM] = 1'b1;
      if (st.rpt != 8'h00) begin
        next_st.rpt = st.rpt - 8'h01;
      end else if (st.wrap) begin
        next_st.rpt = RATA_RPT_MAX;
      end else begin
        next_st.arm = 1'b0;
        irq_set[RATA_IRQ_EXPIRE] = 1'b1;
      end
    end
    if (wr) begin
      case (paddr)
        RATA_OFS_ALARM: begin
          next_st.arm  = pwdata[RATA_ALM_ARM];
          next_st.wrap = pwdata[RATA_ALM_WRAP];
          next_st.ivl  = pwdata[RATA_ALM_IVL +: 4];
          next_st.rpt  = pwdata[RATA_ALM_RPT +: 8];
          if (!st.arm) begin
            next_st.pulse = pwdata[RATA_ALM_PIV];
          end
        end
        RATA_OFS_CTRL: begin
          next_st.ctrl_on     = pwdata[RATA_CTRL_ON];
          next_st.ctrl_unlock = pwdata[RATA_CTRL_UNLK];
        end
        RATA_OFS_ADATE: begin
          next_st.ad_month = pwdata[RATA_AD_MONTH +: 4];
          next_st.ad_day   = pwdata[RATA_AD_DAY +: 5];
        end
        RATA_OFS_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~pwdata[1:0];
        RATA_OFS_IRQ_MASK: next_st.irq_mask = pwdata[1:0];
        default: next_st.err = st.err;
      endcase
    end
    // A new event outranks a clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | irq_set;
    // Other reset sources spare the alarm fields
    if (soft_reset) begin
      next_st.ctrl_on     = CORE_RST.ctrl_on;
      next_st.ctrl_unlock = CORE_RST.ctrl_unlock;
      next_st.ad_month    = CORE_RST.ad_month;
      next_st.ad_day      = CORE_RST.ad_day;
      next_st.irq_stat    = CORE_RST.irq_stat;
      next_st.irq_mask    = CORE_RST.irq_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata      = st.rdata;
  assign pslverr     = st.err && psel && penable;
  assign pready      = 1'b1;
  assign alarm_pulse = st.pulse;
  assign irq         = |(st.irq_stat & st.irq_mask);
endmodule // rata_top

/* tb/rata_top_properties.sv */
`timescale 1ns/10ps
module rata_top_properties #(
  parameter int unsigned RTC_DIV = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        soft_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        alarm_pulse,
  input wire logic        irq
);
  import rata_pkg::*;
  logic wr_armed;
  logic a_wr;
  logic a_rd;
  logic t_rd;
  assign a_wr = psel && penable && pwrite && (paddr == RATA_OFS_ALARM);
  assign a_rd = psel && penable && !pwrite && (paddr == RATA_OFS_ALARM);
  assign t_rd = psel && penable && !pwrite && (paddr == RATA_OFS_TIME);
  // Last written arm bit; hardware may disarm but never arms, so zero is a safe claim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_armed <= 1'b0;
    end else if (a_wr) begin
      wr_armed <= pwdata[15];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  hours_bcd_a: assert property (t_rd |-> prdata[31:28] <= 4'h2 && prdata[27:24] <= 4'h9)
    else $error("hours digits out of range");
  minutes_bcd_a: assert property (t_rd |-> prdata[23:20] <= 4'h5 && prdata[19:16] <= 4'h9)
    else $error("minutes digits out of range");
  seconds_bcd_a: assert property (t_rd |-> prdata[15:12] <= 4'h5 && prdata[11:8] <= 4'h9)
    else $error("seconds digits out of range");
  time_low_zero_a: assert property (t_rd |-> prdata[7:0] == 8'h00)
    else $error("time low byte not zero");
  alarm_upper_zero_a: assert property (a_rd |-> prdata[31:16] == 16'h0000)
    else $error("alarm upper half not zero");
  piv_load_a: assert property (a_wr && !wr_armed && !pwdata[15] |=> alarm_pulse == $past(pwdata[13]))
    else $error("pulse level not loaded");
  pulse_idle_a: assert property (!wr_armed && !a_wr |=> $stable(alarm_pulse))
    else $error("pulse moved while disarmed");
  piv_live_a: assert property (a_rd && prdata[15] |-> prdata[13] == $past(alarm_pulse))
    else $error("armed readback not live pulse");
endmodule // rata_top_properties

bind rata_top rata_top_properties #(.RTC_DIV(RTC_DIV)) u_props (
  .pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .alarm_pulse(alarm_pulse), .irq(irq));

/* tb/rata_top_tb.sv */
`timescale 1ns/10ps
module rata_top_tb;
  import rata_pkg::*;
  localparam int unsigned DIV = 2;
  localparam logic [31:0] M = 32'hffffefff;
  logic        pclk;
  logic        presetn;
  logic        soft_reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        alarm_pulse;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          cmp_count;

  rata_top #(.RTC_DIV(DIV)) uut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_pulse(alarm_pulse), .irq(irq));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Waits as long as the slave needs; only the watchdog ends a hung access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs launched by the access edge are looked at one edge later
    @(posedge pclk);
  endtask

  // Rereads until two reads agree, since count and arm cross a rollover
  task automatic rd_alarm();
    logic [31:0] prev;
    int k;
    apb(1'b0, RATA_OFS_ALARM, 32'h0);
    k = 0;
    do begin
      prev = rd;
      apb(1'b0, RATA_OFS_ALARM, 32'h0);
      k++;
    end while (prev !== rd && k < 8);
    chk(rd, prev);
  endtask

  task automatic wait_pulse(input logic old);
    int k;
    k = 0;
    while (alarm_pulse === old && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, alarm_pulse}, {31'h0, ~old});
    // Keep clear of the unsafe window before touching alarm fields
    repeat (64) @(posedge pclk);
  endtask

  task automatic t_fields();
    rd_alarm();
    chk(rd & M, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, RATA_OFS_ALARM, 32'h4000 | (i << 8) | (i + 32'h30));
      rd_alarm();
      chk(rd & M, 32'h4000 | (i << 8) | (i + 32'h30));
    end
    apb(1'b1, RATA_OFS_ALARM, 32'h25a5);
    chk({31'h0, alarm_pulse}, 32'h1);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd_alarm();
    chk(rd & M, 32'h25a5);
    apb(1'b1, RATA_OFS_ALARM, 32'h0);
    chk({31'h0, alarm_pulse}, 32'h0);
    $display("fields test done");
  endtask

  task automatic t_time();
    apb(1'b1, RATA_OFS_CTRL, 32'h8);
    apb(1'b1, RATA_OFS_TIME, 32'h235958ff);
    apb(1'b0, RATA_OFS_TIME, 32'h0);
    chk(rd, 32'h23595800);
    apb(1'b1, RATA_OFS_CTRL, 32'h0);
    apb(1'b1, RATA_OFS_TIME, 32'h12345600);
    apb(1'b0, RATA_OFS_TIME, 32'h0);
    chk(rd, 32'h23595800);
    apb(1'b0, 8'h18, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("time test done");
  endtask

  task automatic t_alarm();
    apb(1'b1, RATA_OFS_IRQ_MASK, 32'h3);
    apb(1'b1, RATA_OFS_ALARM, 32'hc000);
    apb(1'b1, RATA_OFS_CTRL, 32'h8000);
    wait_pulse(1'b0);
    rd_alarm();
    chk(rd & M, 32'he0ff);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, RATA_OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, RATA_OFS_IRQ_MASK, 32'h3);
    apb(1'b1, RATA_OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, RATA_OFS_ALARM, 32'h8000);
    chk({31'h0, alarm_pulse}, 32'h1);
    wait_pulse(1'b1);
    rd_alarm();
    chk(rd & 32'hffffcfff, 32'h0);
    apb(1'b0, RATA_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, RATA_OFS_IRQ_STAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    $display("alarm test done");
  endtask

  task automatic t_reset();
    apb(1'b1, RATA_OFS_ALARM, 32'h45a5);
    rd_alarm();
    chk(rd & M, 32'h45a5);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_alarm();
    chk(rd & M, 32'h0);
    $display("reset test done");
  endtask

  initial begin
    presetn = 1'b0;
    soft_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_fields();
    t_time();
    t_alarm();
    t_reset();
    end_sim();
  end

  initial begin
    repeat (95000) @(posedge pclk);
    err_count++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // rata_top_tb
